// [pkg/cbs_pkg.sv]
// Types shared by the bus cycle sequencer modules
package cbs_pkg;

  typedef enum logic [2:0]
  {
    CBS_BRANCH_OP = 3'h0,
    CBS_MULTIPLY_OP = 3'h1,
    CBS_WAIT_FOR_INTERRUPT_OP = 3'h2,
    CBS_INTERRUPT_RETURN_OP = 3'h3,
    CBS_SOFTWARE_TRAP_OP = 3'h4,
    CBS_BRANCH_SUBROUTINE_OP = 3'h5
  } cbs_op_type;

  typedef enum logic [4:0]
  {
    CBS_ST_IDLE = 5'h01,
    CBS_ST_RUN = 5'h02,
    CBS_ST_HALT = 5'h04,
    CBS_ST_VEC = 5'h08,
    CBS_ST_FIN = 5'h10
  } cbs_state_type;

  typedef struct packed
  {
    logic [15:0] addr;
    logic rw;
    logic [7:0] data;
  } cbs_bus_type;

endpackage

// [pkg/cbs_regs.svh]
// Cycle counts, fixed addresses and timing constants of the bus cycle sequencer
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

`define CBS_CYC_WAIT_OP 4'd9
`define CBS_CYC_MUL_OP 4'd10
`define CBS_CYC_BRANCH_OP 4'd3
`define CBS_CYC_RTI_OP 4'd10
`define CBS_CYC_SWI_OP 4'd12
`define CBS_CYC_BSR_OP 4'd6
`define CBS_ADDR_IDLE 16'hffff
`define CBS_ADDR_SWI_VEC_HI 16'hfffa
`define CBS_ADDR_SWI_VEC_LO 16'hfffb
`define CBS_WAIT_SP_BELOW 16'h0007
`define CBS_IRQ_VEC_DEFAULT 16'hfff8
`define CBS_CYCLE_DIV_DEFAULT 1

`endif

// [pkg/cbs_tick_if.sv]
// Machine cycle enable passed from the divider to the sequencer
`timescale 1ns/1ps
interface cbs_tick_if;
  logic cyc_en;
  modport src (output cyc_en);
  modport dst (input cyc_en);
endinterface

// [src/cbs_cycle_div.sv]
// Divider that makes the one-cycle machine cycle enable
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_cycle_div #(
  parameter int unsigned DIV = `CBS_CYCLE_DIV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  cbs_tick_if.src tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic en_q;
  logic en_d;

  always_comb
  begin
    en_d = (cnt_q == 8'(DIV - 1));
    cnt_d = en_d ? 8'h00 : cnt_q + 8'h01;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 8'h00;
      en_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  assign tick.cyc_en = en_q;
endmodule

// [src/cbs_sequencer.sv]
// Cycle by cycle bus sequencer for trap, wait, return, multiply and branch instructions
//
// Functional notes
// RULE1: Wait op takes 9 cycles; cycles 1-2 read opcode address and next.
// RULE2: Wait op cycles 3-9 write return, index, A, B, flags to SP-0..SP-6.
// RULE3: While halted, repeat reads at original stack pointer minus seven.
// RULE4: Wait op never floats any port; bus keeps driving.
// RULE5: Multiply 10 cycles, branch 3; internal cycles read FFFF.
// RULE6: Return 10 reads; dummy SP read, then flags, B, A from SP+1..SP+3.
// RULE7: Return cycles 7-10 pull index high, low, PC high, low from SP+4..+7.
// RULE8: Trap takes 12 cycles; after two reads pushes same seven bytes as wait.
// RULE9: Trap cycle 10 dummy read SP-7; cycles 11-12 read FFFA then FFFB.
// RULE10: Subroutine branch 6 cycles: fetches, FFFF, target read, push return low, high.
// RULE11: Halt ends on unmasked interrupt or reset, going straight to vector fetch; here reset returns to idle with no vector fetch.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_sequencer #(
  parameter int unsigned CYCLE_DIV = `CBS_CYCLE_DIV_DEFAULT,
  parameter logic [15:0] IRQ_VECTOR = `CBS_IRQ_VEC_DEFAULT
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire cbs_pkg::cbs_op_type op_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic [15:0] target_i,
  input wire logic [15:0] x_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [7:0] ccr_i,
  input wire logic irq_i,
  input wire logic [7:0] data_i,
  output logic [15:0] addr_o,
  output logic rw_o,
  output logic [7:0] data_o,
  output logic bus_valid_o,
  output logic bus_drive_o,
  output logic busy_o,
  output logic halted_o,
  output logic done_o,
  output logic [15:0] vector_o
);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed
  {
    cbs_pkg::cbs_state_type st;
    cbs_pkg::cbs_op_type op;
    logic [3:0] cyc;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] tgt;
    logic [15:0] x;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ccr;
    cbs_pkg::cbs_bus_type bus;
    logic valid;
    logic drive;
    logic done;
    logic busy;
    logic halt;
    logic [1:0] cap;
    logic [15:0] vec;
  } cbs_core_type;

  cbs_core_type q;
  cbs_core_type d;
  cbs_tick_if tick ();

  cbs_cycle_div #(
    .DIV(CYCLE_DIV)
  ) u_div (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick(tick)
  );

  // ******************************************************************
  // Cycle helpers
  // ******************************************************************
  function automatic logic [3:0] cycle_total(input cbs_pkg::cbs_op_type op);
    case (op)
      cbs_pkg::CBS_BRANCH_OP: cycle_total = `CBS_CYC_BRANCH_OP; // [RULE5]
      cbs_pkg::CBS_MULTIPLY_OP: cycle_total = `CBS_CYC_MUL_OP; // [RULE5]
      cbs_pkg::CBS_WAIT_FOR_INTERRUPT_OP: cycle_total = `CBS_CYC_WAIT_OP; // [RULE1]
      cbs_pkg::CBS_INTERRUPT_RETURN_OP: cycle_total = `CBS_CYC_RTI_OP; // [RULE6]
      cbs_pkg::CBS_SOFTWARE_TRAP_OP: cycle_total = `CBS_CYC_SWI_OP; // [RULE8]
      default: cycle_total = `CBS_CYC_BSR_OP; // [RULE10]
    endcase
  endfunction

  function automatic cbs_pkg::cbs_bus_type rd(input logic [15:0] addr);
    rd = '{addr: addr, rw: 1'b1, data: 8'h00};
  endfunction

  function automatic cbs_pkg::cbs_bus_type wr(input logic [15:0] addr, input logic [7:0] data);
    wr = '{addr: addr, rw: 1'b0, data: data};
  endfunction

  // Push order shared by wait and trap: return, index, A, B, flags
  function automatic logic [7:0] push_byte(input cbs_core_type s, input logic [3:0] idx);
    logic [15:0] ret;
    ret = s.pc + 16'h0001;
    case (idx)
      4'h0: push_byte = ret[7:0];
      4'h1: push_byte = ret[15:8];
      4'h2: push_byte = s.x[7:0];
      4'h3: push_byte = s.x[15:8];
      4'h4: push_byte = s.a;
      4'h5: push_byte = s.b;
      default: push_byte = s.ccr;
    endcase
  endfunction

  function automatic cbs_pkg::cbs_bus_type step(input cbs_core_type s);
    logic [3:0] k;
    logic [15:0] ret2;
    k = s.cyc - 4'h3;
    ret2 = s.pc + 16'h0002;
    step = rd(`CBS_ADDR_IDLE);
    if (s.cyc == 4'h1)
      step = rd(s.pc); // [RULE1] [RULE8]
    else if (s.cyc == 4'h2)
      step = rd(s.pc + 16'h0001); // [RULE1] [RULE8]
    else
    begin
      case (s.op)
        cbs_pkg::CBS_WAIT_FOR_INTERRUPT_OP:
          step = wr(s.sp - 16'(k), push_byte(s, k)); // [RULE2]
        cbs_pkg::CBS_SOFTWARE_TRAP_OP:
        begin
          if (s.cyc <= 4'h9)
            step = wr(s.sp - 16'(k), push_byte(s, k)); // [RULE8]
          else if (s.cyc == 4'ha)
            step = rd(s.sp - `CBS_WAIT_SP_BELOW); // [RULE9]
          else if (s.cyc == 4'hb)
            step = rd(`CBS_ADDR_SWI_VEC_HI); // [RULE9]
          else
            step = rd(`CBS_ADDR_SWI_VEC_LO); // [RULE9]
        end
        cbs_pkg::CBS_INTERRUPT_RETURN_OP:
          step = rd(s.sp + 16'(k)); // [RULE6] [RULE7]
        cbs_pkg::CBS_BRANCH_SUBROUTINE_OP:
        begin
          if (s.cyc == 4'h3)
            step = rd(`CBS_ADDR_IDLE); // [RULE10]
          else if (s.cyc == 4'h4)
            step = rd(s.tgt); // [RULE10]
          else if (s.cyc == 4'h5)
            step = wr(s.sp, ret2[7:0]); // [RULE10]
          else
            step = wr(s.sp - 16'h0001, ret2[15:8]); // [RULE10]
        end
        default:
          step = rd(`CBS_ADDR_IDLE); // [RULE5]
      endcase
    end
  endfunction

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.drive = 1'b1; // [RULE4]
    if (tick.cyc_en)
    begin
      // Read data belongs to the machine cycle that just ended
      if (q.cap == 2'b01)
        d.vec[15:8] = data_i;
      if (q.cap == 2'b10)
        d.vec[7:0] = data_i;
      d.cap = 2'b00;
    end
    case (q.st)
      cbs_pkg::CBS_ST_IDLE:
      begin
        d.valid = 1'b0;
        if (start_i)
        begin
          d.st = cbs_pkg::CBS_ST_RUN;
          d.op = op_i;
          d.cyc = 4'h1;
          d.pc = pc_i;
          d.sp = sp_i;
          d.tgt = target_i;
          d.x = x_i;
          d.a = a_i;
          d.b = b_i;
          d.ccr = ccr_i;
        end
      end
      cbs_pkg::CBS_ST_RUN:
      begin
        if (tick.cyc_en)
        begin
          d.bus = step(q);
          d.valid = 1'b1;
          d.cyc = q.cyc + 4'h1;
          if (q.op == cbs_pkg::CBS_SOFTWARE_TRAP_OP && q.cyc == 4'hb)
            d.cap = 2'b01;
          if (q.op == cbs_pkg::CBS_SOFTWARE_TRAP_OP && q.cyc == 4'hc)
            d.cap = 2'b10;
          if (q.cyc == cycle_total(q.op))
          begin
            if (q.op == cbs_pkg::CBS_WAIT_FOR_INTERRUPT_OP)
              d.st = cbs_pkg::CBS_ST_HALT;
            else
              d.st = cbs_pkg::CBS_ST_FIN;
          end
        end
      end
      cbs_pkg::CBS_ST_HALT:
      begin
        if (tick.cyc_en)
        begin
          d.valid = 1'b1;
          // Registers are already stacked, so wake goes straight to the vector
          if (irq_i)
          begin
            d.bus = rd(IRQ_VECTOR); // [RULE11]
            d.cap = 2'b01;
            d.st = cbs_pkg::CBS_ST_VEC;
          end
          else
            d.bus = rd(q.sp - `CBS_WAIT_SP_BELOW); // [RULE3]
        end
      end
      cbs_pkg::CBS_ST_VEC:
      begin
        if (tick.cyc_en)
        begin
          d.bus = rd(IRQ_VECTOR + 16'h0001); // [RULE11]
          d.cap = 2'b10;
          d.st = cbs_pkg::CBS_ST_FIN;
        end
      end
      cbs_pkg::CBS_ST_FIN:
      begin
        if (tick.cyc_en)
        begin
          d.valid = 1'b0;
          d.bus = rd(`CBS_ADDR_IDLE);
          d.done = 1'b1;
          d.st = cbs_pkg::CBS_ST_IDLE;
        end
      end
      default:
        d.st = cbs_pkg::CBS_ST_IDLE;
    endcase
    // Status pins are registered copies of the next state, so they keep state timing
    d.busy = (d.st != cbs_pkg::CBS_ST_IDLE);
    d.halt = (d.st == cbs_pkg::CBS_ST_HALT);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      q.st <= cbs_pkg::CBS_ST_IDLE;
      q.bus <= '{addr: `CBS_ADDR_IDLE, rw: 1'b1, data: 8'h00};
      q.drive <= 1'b1; // [RULE4]
    end
    else
      q <= d;
  end

  assign addr_o = q.bus.addr;
  assign rw_o = q.bus.rw;
  assign data_o = q.bus.data;
  assign bus_valid_o = q.valid;
  assign bus_drive_o = q.drive;
  assign busy_o = q.busy;
  assign halted_o = q.halt;
  assign done_o = q.done;
  assign vector_o = q.vec;
endmodule

// [test/cbs_mem_model.sv]
// Memory model on the far side of the sequencer bus
`timescale 1ns/1ps
module cbs_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rw_i,
  input wire logic valid_i,
  output logic [7:0] rdata_o
);
  logic [7:0] last_q = 8'h00;
  // Outside a read the line flips each cycle, so a stale byte never passes
  assign rdata_o = (valid_i === 1'b1 && rw_i === 1'b1) ? (addr_i[7:0] ^ 8'h5a) : ~last_q;
  always @(posedge clk_i)
    last_q <= rdata_o;
endmodule

// [test/cbs_seq_chk.sv]
// Port checker for the bus cycle sequencer
`timescale 1ns/1ps
module cbs_seq_chk #(
  parameter logic [15:0] IRQ_VECTOR = 16'hfff8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire cbs_pkg::cbs_op_type op_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic [15:0] target_i,
  input wire logic irq_i,
  input wire logic [15:0] addr_o,
  input wire logic rw_o,
  input wire logic bus_valid_o,
  input wire logic bus_drive_o,
  input wire logic busy_o,
  input wire logic halted_o,
  input wire logic done_o
);
  logic tk;
  assign tk = !busy_o && start_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_DRIVE: assert property (bus_drive_o)
    else $error("bus drive dropped");
  AST_FIRST: assert property (tk |-> ##2 bus_valid_o && rw_o && addr_o == $past(pc_i, 2))
    else $error("first cycle wrong");
  AST_SECOND: assert property (tk |-> ##3 rw_o && addr_o == $past(pc_i, 3) + 16'h0001)
    else $error("second cycle wrong");
  AST_BRANCH: assert property (tk && op_i == cbs_pkg::CBS_BRANCH_OP |-> ##4
    (addr_o == 16'hffff && rw_o) ##1 done_o) else $error("branch cycles wrong");
  AST_MUL: assert property (tk && op_i == cbs_pkg::CBS_MULTIPLY_OP |-> ##4
    (addr_o == 16'hffff && rw_o) [*8] ##1 done_o) else $error("multiply cycles wrong");
  AST_RTI: assert property (tk && op_i == cbs_pkg::CBS_INTERRUPT_RETURN_OP |-> ##4
    (rw_o && addr_o == $past(sp_i, 4)) ##1 (rw_o && bus_valid_o) [*7] ##1 done_o)
    else $error("return cycles wrong");
  AST_TRAP: assert property (tk && op_i == cbs_pkg::CBS_SOFTWARE_TRAP_OP |-> ##4
    (!rw_o) [*7] ##1 rw_o ##1 addr_o == 16'hfffa ##1 addr_o == 16'hfffb ##1 done_o)
    else $error("trap cycles wrong");
  AST_WAIT: assert property (tk && op_i == cbs_pkg::CBS_WAIT_FOR_INTERRUPT_OP |-> ##4
    (!rw_o && bus_valid_o) [*7] ##1 rw_o) else $error("wait pushes wrong");
  AST_BSR: assert property (tk && op_i == cbs_pkg::CBS_BRANCH_SUBROUTINE_OP |-> ##4
    addr_o == 16'hffff ##1 addr_o == $past(target_i, 5) ##1 (!rw_o && addr_o == $past(sp_i, 6))
    ##1 (!rw_o && addr_o == $past(sp_i, 7) - 16'h0001) ##1 done_o)
    else $error("subroutine branch cycles wrong");
  AST_HALT: assert property (halted_o && $past(halted_o) && $past(halted_o, 2)
    && !$past(irq_i) && !$past(irq_i, 2) |-> rw_o && addr_o == $past(addr_o))
    else $error("halt reads moved");
  AST_IRQ: assert property (halted_o && irq_i |-> ##[1:4] (addr_o == IRQ_VECTOR && rw_o))
    else $error("no vector fetch after interrupt");
  AST_DONE: assert property (done_o |=> !busy_o && !done_o)
    else $error("done not a single pulse");
  cover property (tk && op_i == cbs_pkg::CBS_SOFTWARE_TRAP_OP);
  cover property (tk && op_i == cbs_pkg::CBS_INTERRUPT_RETURN_OP);
  cover property (halted_o && irq_i);
endmodule
bind cbs_sequencer cbs_seq_chk #(.IRQ_VECTOR(IRQ_VECTOR)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .op_i(op_i), .pc_i(pc_i),
  .sp_i(sp_i), .target_i(target_i), .irq_i(irq_i), .addr_o(addr_o), .rw_o(rw_o),
  .bus_valid_o(bus_valid_o), .bus_drive_o(bus_drive_o), .busy_o(busy_o),
  .halted_o(halted_o), .done_o(done_o));

// [test/testbench.sv]
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] IV = 16'hfff8;
  logic clk_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, irq_i = 1'b0;
  cbs_pkg::cbs_op_type op_i = cbs_pkg::CBS_BRANCH_OP;
  logic [15:0] pc_i = 16'h0000, sp_i = 16'h0000, target_i = 16'h0000, x_i = 16'h0000;
  logic [7:0] a_i = 8'h00, b_i = 8'h00, ccr_i = 8'h00, data_i, data_o;
  logic [15:0] addr_o, vector_o;
  logic rw_o, bus_valid_o, bus_drive_o, busy_o, halted_o, done_o;
  int failures = 0, checked = 0, seed = 45193;
  logic [24:0] exq [$];
  always #5 clk_i = ~clk_i;
  cbs_sequencer #(.IRQ_VECTOR(IV)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .start_i(start_i), .op_i(op_i), .pc_i(pc_i), .sp_i(sp_i), .target_i(target_i),
    .x_i(x_i), .a_i(a_i), .b_i(b_i), .ccr_i(ccr_i), .irq_i(irq_i), .data_i(data_i),
    .addr_o(addr_o), .rw_o(rw_o), .data_o(data_o), .bus_valid_o(bus_valid_o),
    .bus_drive_o(bus_drive_o), .busy_o(busy_o), .halted_o(halted_o), .done_o(done_o),
    .vector_o(vector_o));
  cbs_mem_model u_mem (.clk_i(clk_i), .addr_i(addr_o), .rw_i(rw_o),
    .valid_i(bus_valid_o), .rdata_o(data_i));
  // ****************************************
  // Shared checks and expected cycle queue
  // ****************************************
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic put(input logic [15:0] a, input logic w, input logic [7:0] d);
    exq.push_back({a, w, d});
  endtask
  // Abort drops reset in the wait state instead of raising the interrupt
  task automatic run(input logic [2:0] op, input bit abort);
    logic [31:0] q, u;
    logic [15:0] s, r;
    logic [24:0] e;
    int h;
    bit fin;
    h = 0;
    fin = 0;
    q = $random(seed);
    u = $random(seed);
    s = (u[15:0] & 16'h7ffe) | 16'h0010;
    r = q[15:0] + ((op == 3'h5) ? 16'h0002 : 16'h0001);
    put(q[15:0], 1'b1, 8'h00);
    put(q[15:0] + 16'h0001, 1'b1, 8'h00);
    if (op == 3'h0 || op == 3'h5)
      put(16'hffff, 1'b1, 8'h00);
    if (op == 3'h1)
      repeat (8) put(16'hffff, 1'b1, 8'h00);
    if (op == 3'h3)
      for (int i = 0; i < 8; i++) put(s + 16'(i), 1'b1, 8'h00);
    if (op == 3'h5)
    begin
      put(q[31:16], 1'b1, 8'h00);
      put(s, 1'b0, r[7:0]);
      put(s - 16'h0001, 1'b0, r[15:8]);
    end
    if (op == 3'h2 || op == 3'h4)
    begin
      put(s, 1'b0, r[7:0]); put(s - 16'h0001, 1'b0, r[15:8]);
      put(s - 16'h0002, 1'b0, u[23:16]); put(s - 16'h0003, 1'b0, u[31:24]);
      put(s - 16'h0004, 1'b0, q[7:0]); put(s - 16'h0005, 1'b0, q[15:8]);
      put(s - 16'h0006, 1'b0, q[23:16]);
    end
    if (op == 3'h4)
    begin
      put(s - 16'h0007, 1'b1, 8'h00); put(16'hfffa, 1'b1, 8'h00); put(16'hfffb, 1'b1, 8'h00);
    end
    if (op == 3'h2 && !abort)
    begin
      put(IV, 1'b1, 8'h00); put(IV + 16'h0001, 1'b1, 8'h00);
    end
    @(posedge clk_i);
    irq_i <= 1'b0;
    op_i <= cbs_pkg::cbs_op_type'(op);
    pc_i <= q[15:0]; target_i <= q[31:16]; sp_i <= s; x_i <= {u[31:24], u[23:16]};
    a_i <= q[7:0]; b_i <= q[15:8]; ccr_i <= q[23:16];
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (int n = 0; n < 200 && !fin; n++)
    begin
      @(negedge clk_i);
      chk(bus_drive_o, "bus drive low");
      if (bus_valid_o === 1'b1 && op == 3'h2 && addr_o === s - 16'h0007 && rw_o === 1'b1)
      begin
        h++;
        chk(halted_o, "not halted during wait reads");
        if (h == 3)
        begin
          @(posedge clk_i);
          irq_i <= !abort;
          arst_n_i <= !abort;
          if (abort)
          begin
            repeat (2) @(posedge clk_i);
            chk(halted_o === 1'b0 && busy_o === 1'b0, "reset left wait");
            arst_n_i <= 1'b1;
            exq.delete();
            return;
          end
        end
      end
      else if (bus_valid_o === 1'b1)
      begin
        e = (exq.size() > 0) ? exq.pop_front() : ~25'h0;
        chk(addr_o === e[24:9] && rw_o === e[8], "bus cycle");
        if (e[8] === 1'b0)
          chk(data_o === e[7:0], "write data");
      end
      fin = (done_o === 1'b1);
    end
    chk(fin && exq.size() == 0, "cycle count");
    if (!fin)
      conclude();
    else if (op == 3'h4)
      chk(vector_o === 16'ha0a1, "trap vector");
    else if (op == 3'h2)
      chk(vector_o === 16'ha2a3, "interrupt vector");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int k = 0; k < 18; k++) run(3'(k % 6), 1'b0);
    run(3'h2, 1'b1);
    run(3'h3, 1'b0);
    conclude();
  end
endmodule
